// *** sip_port.v ***
// Two-wire slave register port with staged register reflection
`timescale 1ns/10ps
`include "sip_map.vh"
module sip_port (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Two-wire link pins
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output reg         sda_oe,
  // Bus address select strap
  input  wire        bus_address_select_pin,
  // Sensor core side
  input  wire        frame_refl,
  input  wire [12:0] act_rd_addr,
  output wire [7:0]  act_rd_data,
  output reg         standby,
  output reg         frame_update_hold_bit,
  output wire        sweep_busy
);
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_DEV   = 7'h02;
  localparam [6:0] S_REGHI = 7'h04;
  localparam [6:0] S_REGLO = 7'h08;
  localparam [6:0] S_WDATA = 7'h10;
  localparam [6:0] S_RDATA = 7'h20;
  localparam [6:0] S_SKIP  = 7'h40;

  // Map a 16-bit register address onto the store
  function map_ok;
    input [15:0] a;
    begin
      map_ok = (a[15:8] >= `SIP_PAGE_BASE) && (a[15:8] <= `SIP_PAGE_LAST);
    end
  endfunction

  function [12:0] map_addr;
    input [15:0] a;
    reg   [7:0]  pg;
    begin
      pg       = a[15:8] - `SIP_PAGE_BASE;
      map_addr = {pg[4:0], a[7:0]}; // R23
    end
  endfunction

  // Reflection class of a store location
  function [1:0] class_of;
    input [12:0] m;
    begin
      if (m == `SIP_MADDR_S_CLASS)
        class_of = `SIP_CLASS_STBY;
      else if (m >= `SIP_MADDR_V_FIRST && m <= `SIP_MADDR_V_LAST)
        class_of = `SIP_CLASS_FRAME;
      else
        class_of = `SIP_CLASS_IMM;
    end
  endfunction

  // Synchronised pins
  wire [2:0] pins_s;
  wire       scl_s = pins_s[2];
  wire       sda_s = pins_s[1];
  wire       sel_s = pins_s[0];

  sip_sync #(
    .W        (3)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({scl_i, sda_i, bus_address_select_pin}),
    .sync_out (pins_s)
  );

  reg        scl_d_r;
  reg        sda_d_r;
  reg [6:0]  state_r;
  reg [3:0]  cnt_r;
  reg [7:0]  rx_r;
  reg [7:0]  tx_r;
  reg        rd_r;
  reg        mack_r;
  reg [15:0] index_r;
  reg [7:0]  hi_r;
  reg        wr_en_r;
  reg [12:0] wr_addr_r;
  reg [7:0]  wr_data_r;
  reg [1:0]  wr_class_r;

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s; // R8
  wire stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  wire [7:0]  rx_byte  = rx_r;
  wire [6:0]  own_addr = sel_s ? `SIP_DEV_ADDR_SEL1 : `SIP_DEV_ADDR_SEL0; // R3 R4
  wire        addr_hit = (rx_byte[7:1] == own_addr) ||
                         (rx_byte[7:1] == `SIP_DEV_ADDR_SHARED); // R5
  wire [7:0]  rd_byte;
  reg         idx_ok_d_r;
  // Out of range index reads as zero rather than an aliased location
  wire [7:0]  rd_val    = idx_ok_d_r ? rd_byte : 8'h00;
  wire [12:0] idx_maddr = map_addr(index_r);
  wire        idx_ok    = map_ok(index_r);

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;

  always @(posedge clk) begin
    if (sys_rst) begin
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      state_r    <= S_IDLE;
      cnt_r      <= 4'h0;
      rx_r       <= 8'h00;
      tx_r       <= 8'h00;
      rd_r       <= 1'b0;
      mack_r     <= 1'b0;
      index_r    <= 16'h0000;
      hi_r       <= 8'h00;
      sda_oe     <= 1'b0;
      wr_en_r    <= 1'b0;
      wr_addr_r  <= 13'h0000;
      wr_data_r  <= 8'h00;
      wr_class_r <= `SIP_CLASS_IMM;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      wr_en_r <= 1'b0;
      if (start_ev) begin
        // Index is kept across a repeated start
        state_r <= S_DEV; // R9
        cnt_r   <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_ev) begin
        state_r <= S_IDLE;
        cnt_r   <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (state_r != S_IDLE && state_r != S_SKIP) begin
        if (scl_rise) begin
          if (cnt_r < `SIP_BYTE_BITS) begin
            rx_r  <= {rx_r[6:0], sda_s}; // R1
            cnt_r <= cnt_r + 4'h1;
          end else if (cnt_r == `SIP_BYTE_BITS) begin
            mack_r <= ~sda_s;
            cnt_r  <= `SIP_ACK_BIT;
          end
        end else if (scl_fall) begin
          if (cnt_r == `SIP_BYTE_BITS) begin
            case (state_r)
              S_DEV: begin
                sda_oe <= addr_hit; // R7
                rd_r   <= rx_byte[0]; // R6
                if (!addr_hit)
                  state_r <= S_SKIP;
              end
              S_REGHI: begin
                hi_r   <= rx_byte; // R25
                sda_oe <= 1'b1;
              end
              S_REGLO: begin
                index_r <= {hi_r, rx_byte}; // R2 R14
                sda_oe  <= 1'b1;
              end
              S_WDATA: begin
                sda_oe     <= 1'b1; // R18
                index_r    <= index_r + 16'h0001; // R14 R18
                wr_en_r    <= idx_ok; // R19
                wr_addr_r  <= idx_maddr;
                wr_data_r  <= rx_byte;
                wr_class_r <= class_of(idx_maddr);
              end
              S_RDATA: begin
                // Release for the master's answer; persists past nack and stop
                sda_oe  <= 1'b0;
                index_r <= index_r + 16'h0001; // R14 R15
              end
              default: begin
                sda_oe <= 1'b0;
              end
            endcase
          end else if (cnt_r == `SIP_ACK_BIT) begin
            cnt_r  <= 4'h0;
            sda_oe <= 1'b0; // R10
            case (state_r)
              S_DEV: begin
                if (rd_r) begin
                  state_r <= S_RDATA; // R13
                  tx_r    <= rd_val;
                  sda_oe  <= ~rd_val[7];
                end else begin
                  state_r <= S_REGHI;
                end
              end
              S_REGHI: state_r <= S_REGLO;
              S_REGLO: state_r <= S_WDATA;
              S_WDATA: state_r <= S_WDATA;
              S_RDATA: begin
                if (mack_r) begin
                  tx_r   <= rd_val; // R16
                  sda_oe <= ~rd_val[7];
                end else begin
                  state_r <= S_SKIP;
                end
              end
              default: state_r <= S_SKIP;
            endcase
          end else if (state_r == S_RDATA) begin
            tx_r   <= {tx_r[6:0], 1'b0}; // R1
            sda_oe <= ~tx_r[6];
          end
        end
      end
    end
  end

  // Store as written over the link; reads return this view
  wire [7:0] sw_rd_data;
  reg [12:0] sw_cnt_r;

  sip_mem #(
    .AW       (`SIP_MEM_AW),
    .DEPTH    (`SIP_MEM_DEPTH)
  ) u_written (
    .clk      (clk),
    .wr_en    (wr_en_r),
    .wr_addr  (wr_addr_r),
    .wr_data  (wr_data_r),
    .rda_addr (idx_maddr),
    .rda_data (rd_byte),
    .rdb_addr (sw_cnt_r),
    .rdb_data (sw_rd_data)
  );

  // Control bits mirrored from the written store
  reg        standby_d_r;
  reg        stby_req_r;
  reg        frame_req_r;
  reg        sw_busy_r;
  reg        sw_ph_r;
  reg [1:0]  sw_class_r;

  wire imm_wr   = wr_en_r && (wr_class_r == `SIP_CLASS_IMM); // R20
  wire sw_write = sw_busy_r && sw_ph_r && !imm_wr &&
                  (class_of(sw_cnt_r) == sw_class_r);
  wire sw_step  = sw_busy_r && sw_ph_r && !imm_wr;

  assign sweep_busy = sw_busy_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      idx_ok_d_r            <= 1'b0;
      standby               <= `SIP_STANDBY_RST;
      standby_d_r           <= `SIP_STANDBY_RST;
      frame_update_hold_bit <= `SIP_HOLD_RST;
      stby_req_r            <= 1'b0;
      frame_req_r           <= 1'b0;
      sw_busy_r             <= 1'b0;
      sw_ph_r               <= 1'b0;
      sw_class_r            <= `SIP_CLASS_IMM;
      sw_cnt_r              <= 13'h0000;
    end else begin
      idx_ok_d_r  <= idx_ok;
      standby_d_r <= standby;
      if (imm_wr && wr_addr_r == `SIP_MADDR_STANDBY)
        standby <= wr_data_r[0]; // R20
      if (imm_wr && wr_addr_r == `SIP_MADDR_HOLD)
        frame_update_hold_bit <= wr_data_r[0];
      if (!sw_busy_r) begin
        sw_cnt_r <= 13'h0000;
        sw_ph_r  <= 1'b0;
        if (stby_req_r) begin
          stby_req_r <= 1'b0;
          sw_class_r <= `SIP_CLASS_STBY;
          sw_busy_r  <= 1'b1;
        end else if (frame_req_r && !frame_update_hold_bit) begin
          frame_req_r <= 1'b0; // R24
          sw_class_r  <= `SIP_CLASS_FRAME;
          sw_busy_r   <= 1'b1;
        end
      end else if (!sw_ph_r) begin
        sw_ph_r <= 1'b1;
      end else if (sw_step) begin
        // Two cycles per location: read issue, then copy
        sw_ph_r <= 1'b0;
        if (sw_cnt_r == `SIP_MADDR_LAST)
          sw_busy_r <= 1'b0;
        else
          sw_cnt_r <= sw_cnt_r + 13'h0001;
      end
      // Requests latch so an event during a sweep is not lost; placed after
      // the launch so an event in the launch cycle wins over the clear
      if (standby_d_r && !standby)
        stby_req_r <= 1'b1; // R21
      if (frame_refl && !frame_update_hold_bit)
        frame_req_r <= 1'b1; // R22 R24
    end
  end

  // Effective store seen by the sensor core
  sip_mem #(
    .AW       (`SIP_MEM_AW),
    .DEPTH    (`SIP_MEM_DEPTH)
  ) u_active (
    .clk      (clk),
    .wr_en    (imm_wr | sw_write), // R20 R21 R22
    .wr_addr  (imm_wr ? wr_addr_r : sw_cnt_r),
    .wr_data  (imm_wr ? wr_data_r : sw_rd_data),
    .rda_addr (act_rd_addr),
    .rda_data (act_rd_data),
    .rdb_addr (act_rd_addr),
    .rdb_data ()
  );
endmodule

// *** sip_map.vh ***
// Constants for the sensor two-wire register port
//
// Overview of operation
// R1: Bytes move most significant bit first, eight bits each.
// R2: A transaction carries a 16-bit register address, then 8-bit data bytes.
// R3: With the select pin low the port answers bus address 0110110.
// R4: With the select pin high the port answers bus address 0110111.
// R5: The shared bus address 0011010 is always answered.
// R6: Direction bit 0 means master writes, 1 means sensor returns data.
// R7: The receiver of every byte returns acknowledge or negative acknowledge.
// R8: Data changes only with clock low; falling data with clock high is start.
// R9: A start without a preceding stop is a repeated start; context kept.
// R10: After an acknowledge bit the driver releases the data line.
// R11: Master sends stop right after any negative acknowledge.
// R12: Random read begins with a dummy write of address, then repeated start.
// R13: On a read request the port acknowledges then drives the indexed register.
// R14: Index loads from the written address, advances at each data byte's ack.
// R15: Index advance survives a read ended by nack and stop.
// R16: Each master acknowledge during a read advances index and sends next byte.
// R17: Master ends every read with nack after the last byte, then stop.
// R18: Each write byte is acknowledged while the address advances.
// R19: 4352 bytes, 256 per page, pages 02h to 12h, all writable.
// R20: Immediate class registers take effect when the write completes.
// R21: Standby class registers take effect once standby is released.
// R22: Frame class registers take effect at the next frame reflection point.
// R23: Address range 30xxh is page 02h, higher ranges follow on.
// R24: While the hold bit is 1, frame class registers are not updated; a frame sweep already running when it is set still copies them.
// R25: Register address goes as two bytes, upper first, each acknowledged.
`ifndef SIP_MAP_VH
`define SIP_MAP_VH

`define SIP_DEV_ADDR_SEL0   7'h36
`define SIP_DEV_ADDR_SEL1   7'h37
`define SIP_DEV_ADDR_SHARED 7'h1a
`define SIP_BYTE_BITS       4'h8
`define SIP_ACK_BIT         4'h9
`define SIP_PAGE_BASE       8'h30
`define SIP_PAGE_LAST       8'h40
`define SIP_MEM_DEPTH       4352
`define SIP_MEM_AW          13
`define SIP_MADDR_STANDBY   13'h0000
`define SIP_MADDR_HOLD      13'h0008
`define SIP_MADDR_S_CLASS   13'h0005
`define SIP_MADDR_V_FIRST   13'h000c
`define SIP_MADDR_V_LAST    13'h00ff
`define SIP_MADDR_LAST      13'h10ff
`define SIP_CLASS_IMM       2'h0
`define SIP_CLASS_STBY      2'h1
`define SIP_CLASS_FRAME     2'h2
`define SIP_STANDBY_RST     1'h1
`define SIP_HOLD_RST        1'h0

`endif

// *** sip_sync.v ***
// Two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/10ps
module sip_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // Asynchronous in, synchronous out
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_r   <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** sip_mem.v ***
// Register store: one write port, two registered read ports
`timescale 1ns/10ps
module sip_mem #(
  parameter AW    = 13,
  parameter DEPTH = 4352
) (
  // Clock
  input  wire          clk,
  // Write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  // Read port a
  input  wire [AW-1:0] rda_addr,
  output reg  [7:0]    rda_data,
  // Read port b
  input  wire [AW-1:0] rdb_addr,
  output reg  [7:0]    rdb_data
);
  reg [7:0] mem [0:DEPTH-1];
  integer   i;

  // Cleared store so unwritten registers read as zero
  initial begin
    for (i = 0; i < DEPTH; i = i + 1)
      mem[i] = 8'h00;
  end

  always @(posedge clk) begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rda_data <= mem[rda_addr];
    rdb_data <= mem[rdb_addr];
  end
endmodule

// *** sip_port_assertions.sv ***
// Pin-level and copy sweep checks for the two-wire register port
`timescale 1ns/10ps
`include "sip_map.vh"
module sip_port_chk (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // Link pins and strap
  input wire        scl_i,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe,
  input wire        bus_address_select_pin,
  // Core side
  input wire        frame_refl,
  input wire [12:0] act_rd_addr,
  input wire [7:0]  act_rd_data,
  input wire        standby,
  input wire        frame_update_hold_bit,
  input wire        sweep_busy
);
  // Two clocks per location, so a whole sweep is never shorter than this
  localparam int SWEEP_MIN = 2 * `SIP_MEM_DEPTH - 1;
  logic [15:0] busy_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always @(posedge clk) begin
    if (sys_rst || !sweep_busy)
      busy_cnt_r <= 16'h0000;
    else
      busy_cnt_r <= busy_cnt_r + 16'h0001;
  end
  sequence s_ack_held;
    sda_oe [*8];
  endsequence
  sequence s_sweep_soon;
    ##[0:8] sweep_busy;
  endsequence
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data pulled low while clock high");
  a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_i)
    else $error("data released while clock high");
  a_oe_stable_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data changed during clock high");
  a_ack_stands: assert property ($rose(sda_oe) |-> s_ack_held)
    else $error("low bit too short");
  a_reset_values: assert property ($fell(sys_rst) |-> standby && !frame_update_hold_bit
    && !sweep_busy)
    else $error("wrong values after reset");
  a_standby_sweep: assert property ($fell(standby) |-> s_sweep_soon)
    else $error("no copy after standby release");
  a_frame_sweep: assert property (frame_refl && !frame_update_hold_bit && !sweep_busy
    |-> s_sweep_soon)
    else $error("no copy at frame point");
  a_hold_blocks: assert property (frame_refl && frame_update_hold_bit && !sweep_busy
    |=> !sweep_busy [*8])
    else $error("copy ran while hold set");
  a_sweep_length: assert property ($fell(sweep_busy) |-> busy_cnt_r >= SWEEP_MIN)
    else $error("copy sweep ended early");
endmodule

bind sip_port sip_port_chk chk_u (.clk, .sys_rst, .scl_i, .sda_i, .sda_o, .sda_oe,
  .bus_address_select_pin, .frame_refl, .act_rd_addr, .act_rd_data, .standby,
  .frame_update_hold_bit, .sweep_busy);

// *** sip_master_model.sv ***
// Behavioural two-wire bus master facing the port
`timescale 1ns/10ps
module sip_master (
  // Bench clock
  input wire   clk,
  // Link wires, sda_m high means released
  output logic scl,
  output logic sda_m,
  input wire   sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Quarter of an 80 ns bit, leaving 20 ns setup and hold
  task automatic q;
    repeat (5) @(negedge clk);
  endtask
  task automatic start;
    sda_m = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_m = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_m = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_m = 1'b1;
    q;
  endtask
  // Data moves only while the clock is low
  task automatic xfer(input logic b, output logic r);
    sda_m = b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) xfer(d[i], a);
    xfer(1'b1, a);
    ack = !a;
  endtask
  // Releases the line for data, drives only its own ack slot
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(!mack, a);
  endtask
endmodule

// *** sensor_i2c_register_port_test.sv ***
// Self-checking bench for the two-wire register port
`timescale 1ns/10ps
`include "sip_map.vh"
module sensor_i2c_register_port_test;
  logic        clk;
  logic        sys_rst;
  logic        sel;
  logic        frame_refl;
  logic [12:0] act_rd_addr;
  wire         scl;
  wire         sda_m;
  wire         sda_o;
  wire         sda_oe;
  wire         standby;
  wire         hold;
  wire         busy;
  wire  [7:0]  act_rd_data;
  wire         sda = sda_m & ~sda_oe;
  int          n_errors;
  int          n_checks;
  sip_port dut_u (.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .bus_address_select_pin(sel), .frame_refl(frame_refl),
    .act_rd_addr(act_rd_addr), .act_rd_data(act_rd_data), .standby(standby),
    .frame_update_hold_bit(hold), .sweep_busy(busy));
  sip_master m_u (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] ra, input logic [23:0] d, input int n);
    logic a;
    m_u.start;
    m_u.wbyte({`SIP_DEV_ADDR_SEL0, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    m_u.wbyte(ra[15:8], a);
    chk({7'h00, a}, 8'h01);
    m_u.wbyte(ra[7:0], a);
    chk({7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m_u.wbyte(d[23-8*i -: 8], a);
      chk({7'h00, a}, 8'h01);
    end
    m_u.stop;
  endtask
  task automatic rd(input logic rnd, input logic [15:0] ra, input logic [23:0] e,
    input int n);
    logic       a;
    logic [7:0] b;
    if (rnd) begin
      m_u.start;
      m_u.wbyte({`SIP_DEV_ADDR_SEL0, 1'b0}, a);
      m_u.wbyte(ra[15:8], a);
      m_u.wbyte(ra[7:0], a);
    end
    m_u.start;
    m_u.wbyte({`SIP_DEV_ADDR_SEL0, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m_u.rbyte(i < n - 1, b);
      chk(b, e[23-8*i -: 8]);
    end
    m_u.stop;
  endtask
  task automatic eff(input logic [12:0] ad, input logic [7:0] e);
    @(negedge clk) act_rd_addr = ad;
    repeat (2) @(negedge clk);
    chk(act_rd_data, e);
  endtask
  task automatic pulse;
    @(negedge clk) frame_refl = 1'b1;
    @(negedge clk) frame_refl = 1'b0;
  endtask
  task automatic sweep_wait;
    int k;
    repeat (20) @(negedge clk);
    k = 0;
    while (busy === 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic t_addr;
    logic [6:0] ad [3];
    logic       a;
    ad = '{`SIP_DEV_ADDR_SEL0, `SIP_DEV_ADDR_SEL1, `SIP_DEV_ADDR_SHARED};
    for (int s = 0; s < 2; s++) begin
      @(negedge clk) sel = s[0];
      repeat (10) @(negedge clk);
      for (int j = 0; j < 3; j++) begin
        m_u.start;
        m_u.wbyte({ad[j], 1'b0}, a);
        m_u.stop;
        chk({7'h00, a}, {7'h00, j == 2 || j == s});
      end
    end
    @(negedge clk) sel = 1'b0;
    repeat (10) @(negedge clk);
    $display("t_addr done");
  endtask
  task automatic t_rw;
    wr(16'h3100, 24'ha55ac3, 3);
    eff(13'h0100, 8'ha5);
    eff(13'h0102, 8'hc3);
    rd(1'b1, 16'h3100, 24'ha55a00, 2);
    rd(1'b0, 16'h0000, 24'hc30000, 1);
    wr(16'h40ff, 24'h990000, 1);
    eff(13'h10ff, 8'h99);
    wr(16'h2f00, 24'h550000, 1);
    rd(1'b1, 16'h2f00, 24'h000000, 1);
    $display("t_rw done");
  endtask
  task automatic t_standby;
    wr(16'h3005, 24'h3c0000, 1);
    eff(13'h0005, 8'h00);
    wr(16'h3000, 24'h000000, 1);
    chk({7'h00, standby}, 8'h00);
    sweep_wait;
    eff(13'h0005, 8'h3c);
    $display("t_standby done");
  endtask
  task automatic t_frame;
    wr(16'h3008, 24'h010000, 1);
    chk({7'h00, hold}, 8'h01);
    wr(16'h3020, 24'h770000, 1);
    pulse;
    repeat (20) @(negedge clk);
    chk({7'h00, busy}, 8'h00);
    eff(13'h0020, 8'h00);
    wr(16'h3008, 24'h000000, 1);
    pulse;
    sweep_wait;
    eff(13'h0020, 8'h77);
    $display("t_frame done");
  endtask
  initial begin
    #300000;
    n_errors++;
    $display("watchdog expired");
    wrap_up;
  end
  initial begin
    n_errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    sel = 1'b0;
    frame_refl = 1'b0;
    act_rd_addr = 13'h0000;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge clk);
    t_addr;
    t_rw;
    t_standby;
    t_frame;
    wrap_up;
  end
endmodule
